// ==== core/multimode_timer.sv ====
// One 16-bit timer channel: timer, event counter, one-shot and PWM modes.
// Assumes pins and strobes synchronous to clk except the two pins, which are resynchronised here.
//
// Summary of operation
// [R1] Timer mode with start flag set decrements once per selected internal tick.
// [R2] Underflow reloads the counter, keeps counting and sets the request bit.
// [R3] Clearing the start flag freezes the counter.
// [R4] Pulse output inverts the output pin at every wrap in timer mode.
// [R5] Gate function starts and stops counting by the input pin level.
// [R6] Gate may count while the pin is low or while it is high.
// [R7] Event mode counts pin edges or overflows of another timer.
// [R8] Free-run event mode wraps without using the reload value.
// [R9] Two-phase option counts up or down by phase of two inputs.
// [R10] One-shot starts on soft, pin or overflow trigger and stops at zero.
// [R11] PWM outputs continuously, 16-bit or 8-bit period, trigger as one-shot.
// [R12] Internal source is main clock by 1, 8, 32 or secondary by 32.
// [R13] Timer and PWM wrap every programmed value plus one ticks.
// [R14] Event ratio is value plus one down, FFFF minus value plus one up.
// [R15] One-shot runs exactly the programmed number of ticks.
// [R16] Pulse output drives the pin without touching any port data register.
// [R17] Timer reads give the live count in timer and event modes only.
// [R18] Software accesses the timer register as whole 16-bit words.
// [R19] Write while counting goes to reload only; stopped, to both.
// [R20] Output pulses ignore port direction; inputs need direction set to input.
// [R21] In event mode the output pin serves as a timer input.
// [R22] Inactive gate level holds the counter.
// [R23] With pulse output, clearing the start flag drives the pin low.
// [R24] Up/down change takes effect at the next effective edge.
// [R25] Pins are synchronised; every count source is a one-cycle enable.
// [R26] Mode selections use a fixed encoding of the mode register.
`timescale 1ns/1ps
`default_nettype none

module multimode_timer
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic timer_input_pin,
    input wire logic timer_phase_pin,
    input wire logic other_overflow,
    input wire logic secondary_clock_tick,
    output logic timer_output_pin,
    output logic timer_output_oe
);

    // ==========================================================
    // State
    typedef enum logic {RUN_IDLE = 1'b0, RUN_ACTIVE = 1'b1} run_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] reload;
        logic [15:0] duty;
        logic [15:0] cfg;
        logic [15:0] rdata;
        logic start;
        logic ir;
        run_t run;
        logic out;
        logic oe;
        logic [4:0] pre;
        logic [4:0] sec;
        logic in_m;
        logic in_q;
        logic in_d;
        logic ph_m;
        logic ph_q;
    } state_t;

    state_t q;
    state_t next_q;

    function automatic logic [1:0] field2(input logic [15:0] v, input int pos);
        field2 = v[pos +: 2];
    endfunction

    // ==========================================================
    // Count sources and selections
    logic [1:0] mode;
    logic [1:0] clksel;
    logic [1:0] gate;
    logic [1:0] trig;
    logic pulse;
    logic int_tick;
    logic gate_ok;
    logic in_rise;
    logic in_fall;
    logic ev_tick;
    logic ev_up;
    logic trigger;
    logic [15:0] period;
    logic [15:0] cmp_cnt;
    logic [15:0] cmp_duty;

    assign mode = field2(q.cfg, timer_pkg::POS_MODE); // [R26]
    assign clksel = field2(q.cfg, timer_pkg::POS_CLKSEL);
    assign gate = field2(q.cfg, timer_pkg::POS_GATE);
    assign trig = field2(q.cfg, timer_pkg::POS_TRIG);
    assign pulse = q.cfg[timer_pkg::POS_PULSE];

    // Dividers run free so a source change never restarts a partial period
    always_comb
    begin
        unique case (clksel) // [R12] [R25]
            timer_pkg::CLK_DIV1: int_tick = 1'b1;
            timer_pkg::CLK_DIV8: int_tick = (q.pre[2:0] == timer_pkg::DIV8_LAST);
            timer_pkg::CLK_DIV32: int_tick = (q.pre == timer_pkg::DIV32_LAST);
            timer_pkg::CLK_SEC32: int_tick = secondary_clock_tick && (q.sec == timer_pkg::DIV32_LAST);
        endcase
    end

    // Edges come from the second and third stages; the first stage feeds nothing else
    assign in_rise = q.in_q && !q.in_d; // [R25]
    assign in_fall = !q.in_q && q.in_d;

    always_comb
    begin
        unique case (gate) // [R5] [R6]
            timer_pkg::GATE_LOW: gate_ok = !q.in_q;
            timer_pkg::GATE_HIGH: gate_ok = q.in_q;
            default: gate_ok = 1'b1;
        endcase
    end

    // Two-phase: step on the input's rising edge, direction from the phase pin
    always_comb
    begin
        if (q.cfg[timer_pkg::POS_TWOPHASE])
        begin
            ev_tick = in_rise; // [R9]
            ev_up = q.ph_q;
        end
        else
        begin
            if (q.cfg[timer_pkg::POS_EVSRC])
                ev_tick = other_overflow; // [R7]
            else
                ev_tick = q.cfg[timer_pkg::POS_RISING] ? in_rise : in_fall;
            // Flag is only looked at on a tick, so a change acts at the next edge
            ev_up = q.cfg[timer_pkg::POS_UP]; // [R24]
        end
    end

    always_comb
    begin
        unique case (trig) // [R10]
            timer_pkg::TRIG_PIN: trigger = in_fall;
            timer_pkg::TRIG_OVF: trigger = other_overflow;
            default: trigger = wr && (addr == timer_pkg::ADDR_TRIGGER);
        endcase
    end

    assign period = q.cfg[timer_pkg::POS_PWM8] ? {8'h00, q.reload[7:0]} : q.reload; // [R11]
    assign cmp_duty = q.cfg[timer_pkg::POS_PWM8] ? {8'h00, q.duty[7:0]} : q.duty;

    // ==========================================================
    // Next state
    always_comb
    begin
        next_q = q;
        cmp_cnt = q.cnt;
        next_q.in_m = timer_input_pin;
        next_q.in_q = q.in_m;
        next_q.in_d = q.in_q;
        next_q.ph_m = timer_phase_pin;
        next_q.ph_q = q.ph_m;
        next_q.pre = q.pre + 5'h01;
        if (secondary_clock_tick)
            next_q.sec = q.sec + 5'h01;
        next_q.rdata = 16'h0000;

        // Clears come first so a same-cycle request bit set wins
        if (wr)
        begin
            unique case (addr)
                timer_pkg::ADDR_TIMER:
                begin
                    next_q.reload = wdata; // [R18] [R19]
                    if (!q.start)
                        next_q.cnt = wdata;
                end
                timer_pkg::ADDR_START: next_q.start = wdata[0];
                timer_pkg::ADDR_MODE: next_q.cfg = wdata;
                timer_pkg::ADDR_STATUS:
                    if (wdata[0])
                        next_q.ir = 1'b0;
                timer_pkg::ADDR_DUTY: next_q.duty = wdata;
                default: ;
            endcase
        end

        if (rd)
        begin
            unique case (addr)
                // Undefined count in one-shot and PWM reads as zero
                timer_pkg::ADDR_TIMER:
                    next_q.rdata = (mode == timer_pkg::MODE_TIMER || mode == timer_pkg::MODE_EVENT)
                                   ? q.cnt : 16'h0000; // [R17]
                timer_pkg::ADDR_START: next_q.rdata = {15'h0000, q.start};
                timer_pkg::ADDR_MODE: next_q.rdata = q.cfg;
                timer_pkg::ADDR_STATUS: next_q.rdata = {14'h0000, q.run, q.ir};
                timer_pkg::ADDR_DUTY: next_q.rdata = q.duty;
                default: ;
            endcase
        end

        if (!q.start)
        begin
            next_q.run = RUN_IDLE; // [R3]
            next_q.out = 1'b0; // [R23]
        end
        else
        begin
            unique case (mode)
                timer_pkg::MODE_TIMER:
                    if (gate_ok && int_tick) // [R1] [R22]
                    begin
                        if (q.cnt == timer_pkg::CNT_RESET)
                        begin
                            next_q.cnt = q.reload; // [R2] [R13]
                            next_q.ir = 1'b1;
                            if (pulse)
                                next_q.out = !q.out; // [R4] [R16]
                        end
                        else
                            next_q.cnt = q.cnt - 16'h0001;
                    end
                timer_pkg::MODE_EVENT:
                    if (ev_tick)
                    begin
                        if (ev_up && q.cnt == timer_pkg::CNT_MAX)
                        begin
                            next_q.cnt = q.cfg[timer_pkg::POS_FREERUN] ? timer_pkg::CNT_RESET : q.reload; // [R8] [R14]
                            next_q.ir = 1'b1;
                            if (pulse)
                                next_q.out = !q.out;
                        end
                        else if (!ev_up && q.cnt == timer_pkg::CNT_RESET)
                        begin
                            next_q.cnt = q.cfg[timer_pkg::POS_FREERUN] ? timer_pkg::CNT_MAX : q.reload; // [R8] [R14]
                            next_q.ir = 1'b1;
                            if (pulse)
                                next_q.out = !q.out;
                        end
                        else
                            next_q.cnt = ev_up ? q.cnt + 16'h0001 : q.cnt - 16'h0001;
                    end
                timer_pkg::MODE_ONESHOT:
                    if (q.run == RUN_IDLE)
                    begin
                        if (trigger) // [R10]
                        begin
                            next_q.cnt = q.reload;
                            next_q.run = (q.reload != timer_pkg::CNT_RESET) ? RUN_ACTIVE : RUN_IDLE;
                            next_q.out = pulse && (q.reload != timer_pkg::CNT_RESET);
                        end
                    end
                    else if (int_tick)
                    begin
                        next_q.cnt = q.cnt - 16'h0001; // [R15]
                        if (q.cnt == 16'h0001)
                        begin
                            next_q.run = RUN_IDLE;
                            next_q.ir = 1'b1;
                            next_q.out = 1'b0;
                        end
                    end
                timer_pkg::MODE_PWM:
                begin
                    if (q.run == RUN_IDLE)
                    begin
                        if (trigger) // [R11]
                        begin
                            next_q.cnt = period;
                            next_q.run = RUN_ACTIVE;
                        end
                    end
                    else if (int_tick)
                    begin
                        if (q.cnt == timer_pkg::CNT_RESET)
                        begin
                            next_q.cnt = period; // [R13]
                            next_q.ir = 1'b1;
                        end
                        else
                            next_q.cnt = q.cnt - 16'h0001;
                    end
                    cmp_cnt = next_q.cnt;
                    next_q.out = (next_q.run == RUN_ACTIVE) && (cmp_cnt < cmp_duty);
                end
            endcase
        end

        // Drive irrespective of port direction; event mode turns the pin into an input
        next_q.oe = (mode != timer_pkg::MODE_EVENT) && (pulse || mode == timer_pkg::MODE_PWM); // [R20] [R21]
        if (mode == timer_pkg::MODE_EVENT)
            next_q.out = 1'b0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '{cnt: timer_pkg::CNT_RESET, reload: timer_pkg::CNT_RESET, duty: 16'h0000,
                   cfg: timer_pkg::CFG_RESET, rdata: 16'h0000, start: 1'b0, ir: 1'b0,
                   run: RUN_IDLE, out: 1'b0, oe: 1'b0, pre: 5'h00, sec: 5'h00,
                   in_m: 1'b0, in_q: 1'b0, in_d: 1'b0, ph_m: 1'b0, ph_q: 1'b0};
        end
        else
        begin
            q <= next_q;
        end
    end

    assign rdata = q.rdata;
    assign timer_output_pin = q.out;
    assign timer_output_oe = q.oe;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic timer_step;
    assign timer_step = q.start && mode == timer_pkg::MODE_TIMER && gate_ok && int_tick
                        && !(wr && addr == timer_pkg::ADDR_MODE);

    count_down_a: assert property (timer_step && q.cnt != 16'h0000 |=> q.cnt == $past(q.cnt) - 16'h0001) // [R1]
        else $error("timer did not decrement on tick");
    underflow_reload_a: assert property (timer_step && q.cnt == 16'h0000 |=> q.cnt == $past(q.reload) && q.ir) // [R2]
        else $error("underflow did not reload and request");
    stop_hold_a: assert property (!q.start && !wr |=> $stable(q.cnt)) // [R3]
        else $error("counter moved while stopped");
    pulse_toggle_a: assert property (timer_step && q.cnt == 16'h0000 && pulse |=> q.out != $past(q.out)) // [R4]
        else $error("pulse output did not invert on wrap");
    gate_hold_a: assert property (q.start && mode == timer_pkg::MODE_TIMER && !gate_ok && !wr // [R22]
                                  |=> $stable(q.cnt))
        else $error("counter moved with gate inactive");
    stopped_low_a: assert property (!q.start |=> !timer_output_pin) // [R23]
        else $error("output not low after stop");
    write_reload_a: assert property (wr && addr == timer_pkg::ADDR_TIMER // [R19]
                                     |=> q.reload == $past(wdata) && ($past(q.start) || q.cnt == $past(wdata)))
        else $error("timer register write misrouted");
    event_input_a: assert property (mode == timer_pkg::MODE_EVENT && !(wr && addr == timer_pkg::ADDR_MODE) // [R21]
                                    |=> !timer_output_oe)
        else $error("output enabled in event mode");
    oneshot_end_a: assert property (q.start && mode == timer_pkg::MODE_ONESHOT && q.run == RUN_ACTIVE // [R15]
                                    && int_tick && q.cnt == 16'h0001 && !wr
                                    |=> q.run == RUN_IDLE && q.cnt == 16'h0000 && q.ir ##1 !timer_output_pin)
        else $error("one-shot did not stop at zero");
    read_live_a: assert property (rd && addr == timer_pkg::ADDR_TIMER && mode == timer_pkg::MODE_TIMER // [R17]
                                  |=> rdata == $past(q.cnt) ##1 rdata == 16'h0000 || $past(rd))
        else $error("timer read wrong");
    // Free-run wrap must ignore whatever reload holds
    free_wrap_a: assert property (q.start && mode == timer_pkg::MODE_EVENT && q.cfg[timer_pkg::POS_FREERUN] // [R8]
                                  && ev_tick && ev_up && q.cnt == 16'hffff
                                  && !(wr && addr == timer_pkg::ADDR_MODE) |=> q.cnt == 16'h0000 && q.ir)
        else $error("free-run wrap loaded a value");
    oneshot_load_a: assert property (q.start && mode == timer_pkg::MODE_ONESHOT && q.run == RUN_IDLE // [R10]
                                     && trigger && q.reload != 16'h0000 && !(wr && addr == timer_pkg::ADDR_MODE)
                                     |=> q.run == RUN_ACTIVE && q.cnt == $past(q.reload))
        else $error("one-shot did not load on trigger");

    wrap_c: cover property (timer_step && q.cnt == 16'h0000);
    event_up_c: cover property (q.start && mode == timer_pkg::MODE_EVENT && ev_tick && ev_up && q.cnt == 16'hffff);
    oneshot_c: cover property (q.run == RUN_ACTIVE && mode == timer_pkg::MODE_ONESHOT ##[1:300] q.run == RUN_IDLE);
    pwm_c: cover property (mode == timer_pkg::MODE_PWM && q.run == RUN_ACTIVE && int_tick && q.cnt == 16'h0000);

endmodule // multimode_timer

`default_nettype wire

// ==== shared/timer_pkg.sv ====
// Constants for the multimode sixteen bit timer channel.
// Assumes a 250 MHz clk and a plain strobe register port with 8-bit byte addresses.
package timer_pkg;

    // ==========================================================
    // Register map (byte addresses, one 16-bit register per word)
    localparam logic [7:0] ADDR_TIMER = 8'h00;
    localparam logic [7:0] ADDR_START = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_TRIGGER = 8'h10;
    localparam logic [7:0] ADDR_DUTY = 8'h14;

    // ==========================================================
    // Mode register field positions
    localparam int POS_MODE = 0;
    localparam int POS_CLKSEL = 2;
    localparam int POS_GATE = 4;
    localparam int POS_PULSE = 6;
    localparam int POS_FREERUN = 7;
    localparam int POS_UP = 8;
    localparam int POS_TWOPHASE = 9;
    localparam int POS_RISING = 10;
    localparam int POS_EVSRC = 11;
    localparam int POS_TRIG = 12;
    localparam int POS_PWM8 = 14;

    // ==========================================================
    // Reset values and encodings
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [4:0] DIV32_LAST = 5'h1f;
    localparam logic [2:0] DIV8_LAST = 3'h7;

    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_ONESHOT = 2'h2;
    localparam logic [1:0] MODE_PWM = 2'h3;

    localparam logic [1:0] CLK_DIV1 = 2'h0;
    localparam logic [1:0] CLK_DIV8 = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [1:0] CLK_SEC32 = 2'h3;

    localparam logic [1:0] GATE_NONE = 2'h0;
    localparam logic [1:0] GATE_LOW = 2'h2;
    localparam logic [1:0] GATE_HIGH = 2'h3;

    localparam logic [1:0] TRIG_SOFT = 2'h0;
    localparam logic [1:0] TRIG_PIN = 2'h1;
    localparam logic [1:0] TRIG_OVF = 2'h2;

endpackage

// ==== test/far_side.sv ====
// Far side of the timer channel: input pin, phase pin, other timer overflow, secondary tick.
// Assumes the bench calls its tasks by hierarchical name, one task at a time per signal.
`timescale 1ns/1ps
`default_nettype none

module far_side
#(
    parameter int SEC_PERIOD = 2
)
(
    input wire logic clk,
    output logic input_pin,
    output logic phase_pin,
    output logic overflow,
    output logic sec_tick
);
    int k = 0;

    initial
    begin
        input_pin = 1'b0;
        phase_pin = 1'b0;
        overflow = 1'b0;
        sec_tick = 1'b0;
    end

    // ==========================================================
    // Secondary clock enable runs free, one cycle per period
    always @(posedge clk)
    begin
        k <= (k + 1) % SEC_PERIOD;
        sec_tick <= (k == SEC_PERIOD - 1);
    end

    // ==========================================================
    // Pin stimulus
    task automatic set_level(input logic v);
        @(posedge clk);
        input_pin <= v;
    endtask

    task automatic set_phase(input logic v);
        @(posedge clk);
        phase_pin <= v;
    endtask

    // Four cycles high, four low: well above the two-sample width the input needs
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge clk);
            input_pin <= 1'b1;
            repeat (4) @(posedge clk);
            input_pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    task automatic fire_ovf(input int n);
        repeat (n)
        begin
            @(posedge clk);
            overflow <= 1'b1;
            @(posedge clk);
            overflow <= 1'b0;
        end
    endtask
endmodule // far_side

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the timer channel, driving its register port and far side.
// Assumes the far side model runs its secondary enable every second clock.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk = 1'b0;
    logic rstn;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata, v, w;
    logic pin_in, pin_ph, ovf, sec, out_pin, out_oe;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int n1, n2;
    // Secondary source is 32 secondary enables, one enable every 2 clocks
    int divs[4] = '{1, 8, 32, 64};

    always #2 clk = ~clk;

    far_side #(.SEC_PERIOD(2)) i_far (.clk(clk), .input_pin(pin_in), .phase_pin(pin_ph),
        .overflow(ovf), .sec_tick(sec));

    multimode_timer i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .timer_input_pin(pin_in), .timer_phase_pin(pin_ph), .other_overflow(ovf),
        .secondary_clock_tick(sec), .timer_output_pin(out_pin), .timer_output_oe(out_oe));

    // ==========================================================
    // Register port and checks
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", name, e, g);
            n_errors++;
        end
    endtask

    task automatic chk_n(input string name, input int e, input int g);
        n_checks++;
        if (g != e)
        begin
            $display("ERROR %s expected %0d seen %0d", name, e, g);
            n_errors++;
        end
    endtask

    // Cycles from one output change to the next; sync first waits for a change
    task automatic gap(input bit sync, output int n);
        logic p;
        int k;
        p = out_pin;
        k = 0;
        while (sync && out_pin === p && k < 9000)
        begin
            @(posedge clk);
            #1 k++;
        end
        p = out_pin;
        n = 0;
        while (out_pin === p && n < 9000)
        begin
            @(posedge clk);
            #1 n++;
        end
    endtask

    // Stop, set mode and value while stopped, clear the request
    task automatic cfg(input logic [15:0] m, input logic [15:0] t);
        wr_reg(timer_pkg::ADDR_START, 16'h0000);
        wr_reg(timer_pkg::ADDR_MODE, m);
        wr_reg(timer_pkg::ADDR_TIMER, t);
        wr_reg(timer_pkg::ADDR_STATUS, 16'h0001);
        wr_reg(timer_pkg::ADDR_START, 16'h0001);
    endtask

    task automatic fire(input int t);
        if (t == 0)
            wr_reg(timer_pkg::ADDR_TRIGGER, 16'h0001);
        else if (t == 1)
            i_far.pulse(1);
        else
            i_far.fire_ovf(1);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] e);
        rd_reg(a, v);
        chk(name, e, (a == timer_pkg::ADDR_STATUS) ? (v & 16'h0001) : v);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_errors++;
            give_verdict;
        end
    end

    // ==========================================================
    // Tests
    initial
    begin
        rstn <= 1'b0;
        wr <= 1'b0;
        rd <= 1'b0;
        addr <= 8'h00;
        wdata <= 16'h0000;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd_chk("mode reset", timer_pkg::ADDR_MODE, timer_pkg::CFG_RESET);
        rd_chk("count reset", timer_pkg::ADDR_TIMER, timer_pkg::CNT_RESET);
        rd_chk("unmapped", 8'h20, 16'h0000);
        $display("test reset done");
        for (int s = 0; s < 4; s++)
        begin
            cfg(16'h0040 | 16'(s << 2), 16'h0003);
            gap(1'b1, n1);
            gap(1'b1, n1);
            chk_n("toggle period", 4 * divs[s], n1);
        end
        wr_reg(timer_pkg::ADDR_START, 16'h0000);
        repeat (3) @(posedge clk);
        chk("pin at stop", 16'h0000, {15'h0000, out_pin});
        rd_reg(timer_pkg::ADDR_TIMER, w);
        repeat (5) @(posedge clk);
        rd_chk("frozen", timer_pkg::ADDR_TIMER, w);
        wr_reg(timer_pkg::ADDR_TIMER, 16'h0123);
        rd_chk("stopped write", timer_pkg::ADDR_TIMER, 16'h0123);
        wr_reg(timer_pkg::ADDR_START, 16'h0001);
        wr_reg(timer_pkg::ADDR_TIMER, 16'h0f00);
        repeat (70) @(posedge clk);
        rd_reg(timer_pkg::ADDR_TIMER, v);
        chk("running write", 16'h0001, {15'h0000, v < 16'h0123});
        $display("test timer mode done");
        i_far.set_level(1'b0);
        cfg(16'h0030, 16'h0100);
        repeat (8) @(posedge clk);
        rd_reg(timer_pkg::ADDR_TIMER, w);
        rd_chk("gate hold", timer_pkg::ADDR_TIMER, w);
        i_far.set_level(1'b1);
        repeat (8) @(posedge clk);
        rd_reg(timer_pkg::ADDR_TIMER, v);
        chk("gate high runs", 16'h0001, {15'h0000, v < w});
        cfg(16'h0020, 16'h0100);
        repeat (8) @(posedge clk);
        rd_chk("gate low hold", timer_pkg::ADDR_TIMER, 16'h0100);
        i_far.set_level(1'b0);
        $display("test gate done");
        cfg(16'h0401, 16'h0002);
        chk("event oe", 16'h0000, {15'h0000, out_oe});
        i_far.pulse(2);
        repeat (6) @(posedge clk);
        rd_chk("event no req", timer_pkg::ADDR_STATUS, 16'h0000);
        rd_chk("event down", timer_pkg::ADDR_TIMER, 16'h0000);
        i_far.pulse(1);
        repeat (6) @(posedge clk);
        rd_chk("event req", timer_pkg::ADDR_STATUS, 16'h0001);
        rd_chk("event reload", timer_pkg::ADDR_TIMER, 16'h0002);
        cfg(16'h0581, 16'hfffe);
        i_far.pulse(2);
        repeat (6) @(posedge clk);
        rd_chk("free run up", timer_pkg::ADDR_TIMER, 16'h0000);
        cfg(16'h0801, 16'h0005);
        i_far.fire_ovf(2);
        repeat (3) @(posedge clk);
        rd_chk("overflow source", timer_pkg::ADDR_TIMER, 16'h0003);
        cfg(16'h0201, 16'h0005);
        i_far.set_phase(1'b1);
        i_far.pulse(2);
        repeat (6) @(posedge clk);
        rd_chk("two phase up", timer_pkg::ADDR_TIMER, 16'h0007);
        i_far.set_phase(1'b0);
        i_far.pulse(1);
        repeat (6) @(posedge clk);
        rd_chk("two phase down", timer_pkg::ADDR_TIMER, 16'h0006);
        $display("test event done");
        for (int t = 0; t < 3; t++)
        begin
            cfg(16'h0042 | 16'(t << 12), 16'h0004);
            fork
                fire(t);
                gap(1'b1, n1);
            join
            chk_n("one shot length", 4, n1);
            rd_chk("one shot req", timer_pkg::ADDR_STATUS, 16'h0001);
        end
        rd_chk("one shot read", timer_pkg::ADDR_TIMER, 16'h0000);
        $display("test one shot done");
        cfg(16'h0003, 16'h0009);
        wr_reg(timer_pkg::ADDR_DUTY, 16'h0003);
        wr_reg(timer_pkg::ADDR_TRIGGER, 16'h0001);
        gap(1'b1, n1);
        gap(1'b0, n2);
        chk_n("pwm period", 10, n1 + n2);
        chk_n("pwm high", 3, (n1 < n2) ? n1 : n2);
        chk("pwm oe", 16'h0001, {15'h0000, out_oe});
        rd_chk("pwm read", timer_pkg::ADDR_TIMER, 16'h0000);
        cfg(16'h4003, 16'h0209);
        wr_reg(timer_pkg::ADDR_TRIGGER, 16'h0001);
        gap(1'b1, n1);
        gap(1'b0, n2);
        chk_n("pwm8 period", 10, n1 + n2);
        $display("test pwm done");
        give_verdict;
    end
endmodule // tb

`default_nettype wire
